// [hw/egm_defs.svh]
// Purpose: constants of the engine map and pump gain register slice
// Assumes: 250 MHz core clock
// Notes:   definitions only
`ifndef EGM_DEFS_SVH
`define EGM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define EGM_ADDR_ENG1_HIGH   8'h70
`define EGM_ADDR_ENG1_LOW    8'h71
`define EGM_ADDR_ENG2_HIGH   8'h72
`define EGM_ADDR_ENG2_LOW    8'h73
`define EGM_ADDR_ENG3_HIGH   8'h74
`define EGM_ADDR_ENG3_LOW    8'h75
`define EGM_ADDR_GAIN        8'h76
`define EGM_UNMAPPED_DATA    8'h00

// ----------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------
`define EGM_MAP_RESET        9'h000
`define EGM_GAIN_RESET       8'h00
`define EGM_GAIN_WMASK       8'hfc
`define EGM_THR_HI           7
`define EGM_THR_LO           6
`define EGM_ADAPT_BIT        5
`define EGM_TMR_HI           4
`define EGM_TMR_LO           3
`define EGM_RETURN_BIT       2
`define EGM_OUT_NINE         8

// ----------------------------------------------------------------
// threshold levels in mV and timer periods in ms
// ----------------------------------------------------------------
`define EGM_THR_MV_SEL0      9'h190
`define EGM_THR_MV_SEL1      9'h12c
`define EGM_THR_MV_SEL2      9'h0c8
`define EGM_THR_MV_SEL3      9'h064
`define EGM_TMR_MS_SEL0      5
`define EGM_TMR_MS_SEL1      10
`define EGM_TMR_MS_SEL2      50
`define EGM_TMR_NONE         24'h000000
`define EGM_CLK_KHZ          250000

// ----------------------------------------------------------------
// serial bus
// ----------------------------------------------------------------
`define EGM_SLAVE_ADDR       7'h2a
`define EGM_BIT_LAST         3'h7
`define EGM_BIT_FIRST        3'h0

`endif

// [hw/egm_pkg.sv]
// Purpose: types of the engine map and pump gain register slice
// Assumes: nothing
// Notes:   states follow gray steps along a write transfer
`default_nettype none
package egm_pkg;
	typedef enum logic [3:0] {
		egm_st_idle      = 4'h0,
		egm_st_addr      = 4'h1,
		egm_st_addr_ack  = 4'h3,
		egm_st_reg       = 4'h2,
		egm_st_reg_ack   = 4'h6,
		egm_st_wdata     = 4'h7,
		egm_st_wdata_ack = 4'h5,
		egm_st_rdata     = 4'h4,
		egm_st_rdata_ack = 4'hc
	} egm_state_t;
endpackage
`default_nettype wire

// [hw/egm_regs.sv]
// Purpose: engine-to-output status and pump gain control registers, serial bus slave
// Assumes: engine drive vectors come from logic on core_clk
// Notes:   bus pins pass three flip-flops; register pointer auto-increments
`include "egm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module egm_regs #(
	parameter logic [6:0]  SLAVE_ADDR    = `EGM_SLAVE_ADDR,
	parameter logic [23:0] TMR_SEL0_CYC  = 24'(`EGM_TMR_MS_SEL0 * `EGM_CLK_KHZ),
	parameter logic [23:0] TMR_SEL1_CYC  = 24'(`EGM_TMR_MS_SEL1 * `EGM_CLK_KHZ),
	parameter logic [23:0] TMR_SEL2_CYC  = 24'(`EGM_TMR_MS_SEL2 * `EGM_CLK_KHZ)
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        scl_pin,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic [8:0]  eng_one_drive,
	input  wire logic [8:0]  eng_two_drive,
	input  wire logic [8:0]  eng_three_drive,
	output logic [1:0]       threshold_sel,
	output logic [8:0]       threshold_mv,
	output logic             adaptive_level_enable,
	output logic [1:0]       timer_sel,
	output logic [23:0]      gain_timer_cycles,
	output logic             gain_return_timer_enable
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic               scl_s1, scl_s2, scl_s3;
	logic               sda_s1, sda_s2, sda_s3;
	egm_pkg::egm_state_t state, next_state;
	logic [2:0]         bit_cnt, next_bit_cnt;
	logic               full, next_full;
	logic               rd_mode, next_rd_mode;
	logic               master_nack, next_master_nack;
	logic [7:0]         shreg, next_shreg;
	logic [7:0]         ptr, next_ptr;
	logic               oe, next_oe;
	logic [8:0]         map_one, next_map_one;
	logic [8:0]         map_two, next_map_two;
	logic [8:0]         map_three, next_map_three;
	logic [7:0]         gain, next_gain;
	logic [8:0]         next_thr_mv;
	logic [23:0]        next_tmr_cyc;
	logic               scl_rise, scl_fall, bus_start, bus_stop;
	logic               wr_gain_fire;
	logic [7:0]         rd_cur;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [8:0] m1,
		input logic [8:0] m2, input logic [8:0] m3, input logic [7:0] g);
		logic [7:0] d;
		d = `EGM_UNMAPPED_DATA;
		case (a)
			`EGM_ADDR_ENG1_HIGH: d = {7'h00, m1[`EGM_OUT_NINE]};
			`EGM_ADDR_ENG1_LOW:  d = m1[7:0];
			`EGM_ADDR_ENG2_HIGH: d = {7'h00, m2[`EGM_OUT_NINE]};
			`EGM_ADDR_ENG2_LOW:  d = m2[7:0];
			`EGM_ADDR_ENG3_HIGH: d = {7'h00, m3[`EGM_OUT_NINE]};
			`EGM_ADDR_ENG3_LOW:  d = m3[7:0];
			`EGM_ADDR_GAIN:      d = g & `EGM_GAIN_WMASK;
			default:             d = `EGM_UNMAPPED_DATA;
		endcase
		return d;
	endfunction

	assign rd_cur   = rd_byte(ptr, map_one, map_two, map_three, gain);
	// edge detectors read only the second and third stages
	assign scl_rise  = scl_s2 & ~scl_s3;
	assign scl_fall  = ~scl_s2 & scl_s3;
	assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] lb;
		lb               = rd_cur;
		next_state       = state;
		next_bit_cnt     = bit_cnt;
		next_full        = full;
		next_rd_mode     = rd_mode;
		next_master_nack = master_nack;
		next_shreg       = shreg;
		next_ptr         = ptr;
		next_oe          = oe;
		next_gain        = gain;
		wr_gain_fire     = 1'b0;
		// live copy every cycle, so a read never sees a stale map
		next_map_one     = eng_one_drive;
		next_map_two     = eng_two_drive;
		next_map_three   = eng_three_drive;
		if (bus_start) begin
			next_state   = egm_pkg::egm_st_addr;
			next_bit_cnt = `EGM_BIT_FIRST;
			next_full    = 1'b0;
			next_oe      = 1'b0;
		end else if (bus_stop) begin
			next_state = egm_pkg::egm_st_idle;
			next_oe    = 1'b0;
		end else begin
			case (state)
				egm_pkg::egm_st_addr, egm_pkg::egm_st_reg, egm_pkg::egm_st_wdata: begin
					if (scl_rise) begin
						next_shreg   = {shreg[6:0], sda_s2};
						next_bit_cnt = bit_cnt + 3'h1;
						next_full    = (bit_cnt == `EGM_BIT_LAST);
					end else if (scl_fall && full) begin
						next_full = 1'b0;
						next_oe   = 1'b1;
						if (state == egm_pkg::egm_st_addr) begin
							next_rd_mode = shreg[0];
							next_state   = egm_pkg::egm_st_addr_ack;
							if (shreg[7:1] != SLAVE_ADDR) begin
								next_oe    = 1'b0;
								next_state = egm_pkg::egm_st_idle;
							end
						end else if (state == egm_pkg::egm_st_reg) begin
							next_ptr   = shreg;
							next_state = egm_pkg::egm_st_reg_ack;
						end else begin
							// read-only and unmapped offsets take the byte and drop it
							if (ptr == `EGM_ADDR_GAIN) begin
								next_gain    = shreg & `EGM_GAIN_WMASK;
								wr_gain_fire = 1'b1;
							end
							next_ptr   = ptr + 8'h01;
							next_state = egm_pkg::egm_st_wdata_ack;
						end
					end
				end
				egm_pkg::egm_st_addr_ack: begin
					if (scl_fall) begin
						next_bit_cnt = `EGM_BIT_FIRST;
						if (rd_mode) begin
							next_shreg = lb;
							next_oe    = ~lb[7];
							next_state = egm_pkg::egm_st_rdata;
						end else begin
							next_oe    = 1'b0;
							next_state = egm_pkg::egm_st_reg;
						end
					end
				end
				egm_pkg::egm_st_reg_ack, egm_pkg::egm_st_wdata_ack: begin
					if (scl_fall) begin
						next_oe      = 1'b0;
						next_bit_cnt = `EGM_BIT_FIRST;
						next_state   = egm_pkg::egm_st_wdata;
					end
				end
				egm_pkg::egm_st_rdata: begin
					if (scl_rise) begin
						next_bit_cnt = bit_cnt + 3'h1;
						next_full    = (bit_cnt == `EGM_BIT_LAST);
					end else if (scl_fall) begin
						if (full) begin
							next_full  = 1'b0;
							next_oe    = 1'b0;
							next_ptr   = ptr + 8'h01;
							next_state = egm_pkg::egm_st_rdata_ack;
						end else begin
							next_shreg = {shreg[6:0], 1'b0};
							next_oe    = ~shreg[6];
						end
					end
				end
				egm_pkg::egm_st_rdata_ack: begin
					if (scl_rise) begin
						next_master_nack = sda_s2;
					end else if (scl_fall) begin
						next_bit_cnt = `EGM_BIT_FIRST;
						if (master_nack) begin
							next_state = egm_pkg::egm_st_idle;
						end else begin
							next_shreg = lb;
							next_oe    = ~lb[7];
							next_state = egm_pkg::egm_st_rdata;
						end
					end
				end
				default: begin
					next_oe = 1'b0;
				end
			endcase
		end
		case (next_gain[`EGM_THR_HI:`EGM_THR_LO])
			2'b00:   next_thr_mv = `EGM_THR_MV_SEL0;
			2'b01:   next_thr_mv = `EGM_THR_MV_SEL1;
			2'b10:   next_thr_mv = `EGM_THR_MV_SEL2;
			default: next_thr_mv = `EGM_THR_MV_SEL3;
		endcase
		case (next_gain[`EGM_TMR_HI:`EGM_TMR_LO])
			2'b00:   next_tmr_cyc = TMR_SEL0_CYC;
			2'b01:   next_tmr_cyc = TMR_SEL1_CYC;
			2'b10:   next_tmr_cyc = TMR_SEL2_CYC;
			default: next_tmr_cyc = `EGM_TMR_NONE;
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		scl_s1 <= scl_pin;
		scl_s2 <= scl_s1;
		scl_s3 <= scl_s2;
		sda_s1 <= sda_in;
		sda_s2 <= sda_s1;
		sda_s3 <= sda_s2;
		if (rst) begin
			state                    <= egm_pkg::egm_st_idle;
			bit_cnt                  <= `EGM_BIT_FIRST;
			full                     <= 1'b0;
			rd_mode                  <= 1'b0;
			master_nack              <= 1'b0;
			shreg                    <= 8'h00;
			ptr                      <= 8'h00;
			oe                       <= 1'b0;
			map_one                  <= `EGM_MAP_RESET;
			map_two                  <= `EGM_MAP_RESET;
			map_three                <= `EGM_MAP_RESET;
			gain                     <= `EGM_GAIN_RESET;
			threshold_mv             <= `EGM_THR_MV_SEL0;
			gain_timer_cycles        <= TMR_SEL0_CYC;
		end else begin
			state                    <= next_state;
			bit_cnt                  <= next_bit_cnt;
			full                     <= next_full;
			rd_mode                  <= next_rd_mode;
			master_nack              <= next_master_nack;
			shreg                    <= next_shreg;
			ptr                      <= next_ptr;
			oe                       <= next_oe;
			map_one                  <= next_map_one;
			map_two                  <= next_map_two;
			map_three                <= next_map_three;
			gain                     <= next_gain;
			threshold_mv             <= next_thr_mv;
			gain_timer_cycles        <= next_tmr_cyc;
		end
	end

	// open drain: only ever pulls low
	assign sda_out                  = 1'b0;
	assign sda_oe                   = oe;
	assign threshold_sel            = gain[`EGM_THR_HI:`EGM_THR_LO];
	assign adaptive_level_enable    = gain[`EGM_ADAPT_BIT];
	assign timer_sel                = gain[`EGM_TMR_HI:`EGM_TMR_LO];
	assign gain_return_timer_enable = gain[`EGM_RETURN_BIT];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_eng1_nine_read: assert property (##1 (ptr == `EGM_ADDR_ENG1_HIGH) |->
		rd_cur == {7'h00, $past(eng_one_drive[8])}) else $error("engine one output nine wrong");
	a_eng1_low_read: assert property (##1 (ptr == `EGM_ADDR_ENG1_LOW) |->
		rd_cur == $past(eng_one_drive[7:0])) else $error("engine one low map wrong");
	a_eng2_nine_read: assert property (##1 (ptr == `EGM_ADDR_ENG2_HIGH) |->
		rd_cur == {7'h00, $past(eng_two_drive[8])}) else $error("engine two output nine wrong");
	a_eng2_low_read: assert property (##1 (ptr == `EGM_ADDR_ENG2_LOW) |->
		rd_cur == $past(eng_two_drive[7:0])) else $error("engine two low map wrong");
	a_eng3_nine_read: assert property (##1 (ptr == `EGM_ADDR_ENG3_HIGH) |->
		rd_cur == {7'h00, $past(eng_three_drive[8])}) else $error("engine three output nine wrong");
	a_eng3_low_read: assert property (##1 (ptr == `EGM_ADDR_ENG3_LOW) |->
		rd_cur == $past(eng_three_drive[7:0])) else $error("engine three low map wrong");
	a_gain_reset_zero: assert property (disable iff (1'b0) rst |=>
		(gain == `EGM_GAIN_RESET && !adaptive_level_enable)) else $error("gain not reset");
	a_thr_level_map: assert property (##1 1'b1 |-> threshold_mv ==
		((threshold_sel == 2'b00) ? `EGM_THR_MV_SEL0 : (threshold_sel == 2'b01) ?
		`EGM_THR_MV_SEL1 : (threshold_sel == 2'b10) ? `EGM_THR_MV_SEL2 : `EGM_THR_MV_SEL3))
		else $error("threshold level wrong");
	a_timer_none: assert property ((timer_sel == 2'b11) ==
		(gain_timer_cycles == `EGM_TMR_NONE)) else $error("timer none mismatch");
	a_gain_write_only: assert property ($changed(gain) |-> $past(wr_gain_fire))
		else $error("gain changed without a write");
	a_return_follows: assert property (wr_gain_fire |=>
		gain_return_timer_enable == $past(shreg[`EGM_RETURN_BIT])) else $error("return bit lost");

endmodule

`default_nettype wire

// [tb/egm_host.sv]
// Purpose: host model that drives the serial register bus
// Assumes: wire level fed back on sda_line, pulled up when released
// Notes:   scl phases of 8 core cycles, twice the slave minimum
`timescale 1ns/1ps
`default_nettype none
module egm_host (
	input  wire logic core_clk,
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda_low
);
	// ------------------------------
	// bit and byte level
	// ------------------------------
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// entered with the bus idle, or mid low phase as a repeated start
	task automatic start_cond();
		sda_low = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_low = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(4);
	endtask
	task automatic stop_cond();
		sda_low = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_low = 1'b0;
		tick(8);
	endtask
	// data only changes mid low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic s);
		sda_low = ~b;
		tick(4);
		scl = 1'b1;
		tick(4);
		s = sda_line;
		tick(4);
		scl = 1'b0;
		tick(4);
	endtask
	// tx of 8'hff releases the line so the slave can drive it
	task automatic xfer(input logic [7:0] tx, input logic ack_tx,
		output logic [7:0] rx, output logic ack_rx);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ack_tx, ack_rx);
	endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the engine map and pump gain registers
// Assumes: small timer counts; slave address at its default
// Notes:   expected values come from a register model in the bench
`include "egm_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        core_clk, rst, scl, sda_low, sda_oe, sda_out, sda, adapt, ret;
	logic [8:0]  e1, e2, e3, thr_mv;
	logic [1:0]  thr_sel, tmr_sel;
	logic [23:0] tmr_cyc;
	int          err_total, tests_run, cycles, gain_q;
	int          tcyc[4] = '{50, 100, 500, 0};
	assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
	egm_regs #(.TMR_SEL0_CYC(24'h000032), .TMR_SEL1_CYC(24'h000064),
		.TMR_SEL2_CYC(24'h0001f4)) dut_u (.core_clk(core_clk), .rst(rst),
		.scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.eng_one_drive(e1), .eng_two_drive(e2), .eng_three_drive(e3),
		.threshold_sel(thr_sel), .threshold_mv(thr_mv), .adaptive_level_enable(adapt),
		.timer_sel(tmr_sel), .gain_timer_cycles(tmr_cyc), .gain_return_timer_enable(ret));
	egm_host host_u (.core_clk(core_clk), .sda_line(sda), .scl(scl), .sda_low(sda_low));
	// ------------------------------
	// model and checks
	// ------------------------------
	function automatic logic [7:0] model(input logic [7:0] ad);
		case (ad)
			8'h70: return {7'h00, e1[8]};
			8'h71: return e1[7:0];
			8'h72: return {7'h00, e2[8]};
			8'h73: return e2[7:0];
			8'h74: return {7'h00, e3[8]};
			8'h75: return e3[7:0];
			8'h76: return 8'(gain_q);
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic ea);
		logic [7:0] r;
		logic       a;
		host_u.xfer(b, 1'b1, r, a);
		chk("ack", ea, a);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		host_u.start_cond();
		send(8'h54, 1'b0);
		send(ad, 1'b0);
		send(d, 1'b0);
		host_u.stop_cond();
		// reserved low bits are dropped
		if (ad == `EGM_ADDR_GAIN) gain_q = d & 8'hfc;
	endtask
	task automatic rd(input logic [7:0] ad, input int n);
		logic [7:0] r;
		logic       a;
		host_u.start_cond();
		send(8'h54, 1'b0);
		send(ad, 1'b0);
		host_u.start_cond();
		send(8'h55, 1'b0);
		for (int i = 0; i < n; i++) begin
			host_u.xfer(8'hff, i == n - 1, r, a);
			chk("read data", model(8'(ad + i)), r);
		end
		host_u.stop_cond();
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		rst = 1'b0;
		gain_q = 0;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	// ------------------------------
	// clock, timeout, sequence
	// ------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32443));
		e1 = 9'h000;
		e2 = 9'h000;
		e3 = 9'h000;
		do_reset();
		chk("threshold mv", 400, thr_mv);
		chk("timer cycles", tcyc[0], tmr_cyc);
		chk("gain fields", 0, {thr_sel, adapt, tmr_sel, ret});
		rd(8'h70, 7);
		repeat (3) begin
			e1 = 9'($urandom);
			e2 = 9'($urandom);
			e3 = 9'($urandom);
			wr(8'h73, 8'hff);
			wr(8'h70, 8'hff);
			rd(8'h70, 6);
		end
		for (int s = 0; s < 4; s++) begin
			wr(8'h76, {2'(s), 1'(s), 2'(3 - s), 1'(~s), 2'b11});
			chk("threshold mv", 400 - 100 * s, thr_mv);
			chk("threshold sel", s, thr_sel);
			chk("adaptive", s & 1, adapt);
			chk("timer sel", 3 - s, tmr_sel);
			chk("timer cycles", tcyc[3 - s], tmr_cyc);
			chk("return timer", ~s & 1, ret);
			rd(8'h76, 1);
		end
		rd(8'h80, 2);
		// a foreign address must not be acknowledged
		host_u.start_cond();
		send(8'h20, 1'b1);
		host_u.stop_cond();
		rd(8'h76, 1);
		do_reset();
		chk("threshold mv", 400, thr_mv);
		chk("gain fields", 0, {thr_sel, adapt, tmr_sel, ret});
		rd(8'h75, 2);
		final_report();
	end
endmodule
`default_nettype wire
